// file: common/smb_pkg.sv
/*
  Shared constants for the mailbox slave register bank: offsets, field
  positions, reset values and bus encodings.
  Assumes a 32-bit AHB-Lite data bus and 8-bit wide registers in the low lane.
*/
package smb_pkg;

  // Offset decode width inside the block's window
  localparam int OFS_W = 12;

  // Register offsets, one aligned word each
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_ADDR_LO = 12'h004;
  localparam logic [11:0] OFS_ADDR_HI = 12'h008;
  localparam logic [11:0] OFS_CONTROL = 12'h00c;
  localparam logic [11:0] OFS_BYTE_CNT = 12'h010;
  localparam logic [11:0] OFS_FLAGS1 = 12'h014;
  localparam logic [11:0] OFS_MASK1 = 12'h018;
  localparam logic [11:0] OFS_FORCE1 = 12'h01c;
  localparam logic [11:0] OFS_FLAGS2 = 12'h020;
  localparam logic [11:0] OFS_MASK2 = 12'h024;
  localparam logic [11:0] OFS_FORCE2 = 12'h028;

  // Address windows relative to the base
  localparam logic [11:0] WIN_SLAVE_HI = 12'h3ff;
  localparam logic [11:0] WIN_MASTER_LO = 12'h400;
  localparam logic [11:0] WIN_MASTER_HI = 12'h4ff;

  // Control field positions
  localparam int CTL_WIDE = 0;
  localparam int CTL_STRETCH = 1;
  localparam int CTL_REF_ADDR = 3;
  localparam int CTL_REF_DATA = 4;
  localparam int CTL_SRC = 5;
  localparam logic [7:0] CTL_MASK = 8'h3b;

  // Group one flag positions
  localparam int IRQ1_DONE = 7;
  localparam int IRQ1_STOP = 6;
  localparam int IRQ1_TX_FULL = 5;
  localparam int IRQ1_TX_EMPTY = 4;
  localparam int IRQ1_TX_AEMPTY = 3;
  localparam int IRQ1_RX_FULL = 2;

  // Group two flag positions and implemented bits
  localparam int IRQ2_CLK_HIGH_TO = 6;
  localparam int IRQ2_CLK_LOW_TO = 5;
  localparam int IRQ2_CHECK_VALUE = 4;
  localparam int IRQ2_CHECK_VALID = 3;
  localparam int IRQ2_RESOLVE_CMD = 2;
  localparam int IRQ2_STOP_ERR = 1;
  localparam int IRQ2_START_ERR = 0;
  localparam logic [7:0] FLAGS2_MASK = 8'h7f;
  localparam logic [7:0] MASK2_MASK = 8'h67;

  // Reset values
  localparam logic [7:0] RST_BYTE_CNT = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [9:0] DEF_OWN_ADDR = 10'h05a;
  localparam logic [31:0] DEF_BASE_ADDR = 32'h0000_0000;

  // AHB-Lite encodings
  localparam int HTRANS_ACTIVE = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {RSP_OK, RSP_ERR1, RSP_ERR2} smb_resp_type;

endpackage

// file: src/smb_ahb_if.sv
/*
  AHB-Lite slave front end: decodes the block window, issues read requests in
  the address phase and write requests in the data phase, answers ERROR.
  Assumes the interconnect drives hready and that reads are answered with
  zero wait states by the register bank.
*/
module smb_ahb_if
  import smb_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter logic [31:0] BASE_ADDR = DEF_BASE_ADDR,
  parameter bit MASTER_EN = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  // Requests to the bank
  output logic rdReq,
  output logic rdMaster,
  output logic [11:0] rdOfs,
  output logic wrReq,
  output logic wrMaster,
  output logic [11:0] wrOfs
);

  logic [ADDR_W-1:0] relAddr;
  logic [31:0] relWide;
  logic inSlave;
  logic inMaster;
  logic accept;
  logic good;
  logic bad;
  logic wrPend_ff, nxt_wrPend;
  logic wrMaster_ff, nxt_wrMaster;
  logic [11:0] wrOfs_ff, nxt_wrOfs;
  smb_resp_type rsp_ff, nxt_rsp;

  // Window decode relative to the base
  assign relAddr = haddr - BASE_ADDR[ADDR_W-1:0];
  assign relWide = 32'(relAddr);
  assign rdOfs = relWide[11:0];
  assign inSlave = (relWide[31:12] == 20'h0) && (rdOfs <= WIN_SLAVE_HI);
  assign inMaster = MASTER_EN && (relWide[31:12] == 20'h0) &&
                    (rdOfs >= WIN_MASTER_LO) && (rdOfs <= WIN_MASTER_HI);

  assign accept = hsel && hready && htrans[HTRANS_ACTIVE];
  // Only the low lane carries register data; higher lanes alone are ignored
  assign good = accept && (inSlave || inMaster) && (hsize <= HSIZE_WORD);
  assign bad = accept && !good;

  assign rdReq = good && !hwrite;
  assign rdMaster = inMaster;

  always_comb begin
    nxt_wrPend = good && hwrite && (rdOfs[1:0] == 2'b00);
    nxt_wrMaster = inMaster;
    nxt_wrOfs = rdOfs;
    nxt_rsp = rsp_ff;
    unique case (rsp_ff)
      RSP_OK: nxt_rsp = bad ? RSP_ERR1 : RSP_OK;
      RSP_ERR1: nxt_rsp = RSP_ERR2;
      RSP_ERR2: nxt_rsp = bad ? RSP_ERR1 : RSP_OK;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrPend_ff <= 1'b0;
      wrMaster_ff <= 1'b0;
      wrOfs_ff <= 12'h000;
      rsp_ff <= RSP_OK;
    end else begin
      wrPend_ff <= nxt_wrPend;
      wrMaster_ff <= nxt_wrMaster;
      wrOfs_ff <= nxt_wrOfs;
      rsp_ff <= nxt_rsp;
    end
  end

  // Two-cycle ERROR: first with the bus held, then released
  assign hreadyout = (rsp_ff != RSP_ERR1);
  assign hresp = (rsp_ff != RSP_OK);
  assign wrReq = wrPend_ff;
  assign wrMaster = wrMaster_ff;
  assign wrOfs = wrOfs_ff;

endmodule

// file: src/smb_regs.sv
/*
  Register bank of the mailbox slave: data port, own address, control,
  expected byte count and two groups of interrupt flags, masks and forces.
  Assumes the slave controller supplies one-cycle event pulses and the
  received byte, and takes configuration levels and push/pop strobes.
*/
// Functional notes
// - Build option includes or removes master register window access.
// - Base address parameter; register offsets decode relative to it.
// - Host address input width is a parameter from 1 to 32.
// - Each register is one 32-bit word, offsets four bytes apart.
// - Own address low holds bits 6:0, resets to parameter, host-writable.
// - Own address high holds bits 9:7, resets to parameter, host-writable.
// - Control: wide address, stretch, refuse address, refuse data, read source.
// - Expected byte count register, resets to zero, read/write.
// - Group one flags reset zero; writing one clears, zero keeps.
// - Group one mask resets zero, one enable per source.
// - Group one force register write-only, sets flags, reads zero.
// - Group two flags reset zero, write one to clear, seven sources.
// - Interrupt output is low during and after reset.
// - External writes go to receive queue; reads from queue or file.
module smb_regs
  import smb_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter logic [31:0] BASE_ADDR = DEF_BASE_ADDR,
  parameter bit MASTER_EN = 1'b1,
  parameter logic [9:0] OWN_ADDR = DEF_OWN_ADDR,
  parameter bit WIDE_ADDR = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irqOut,
  // Host data port to the queues
  input wire logic [7:0] rxByte,
  output logic rxPop,
  output logic [7:0] txByte,
  output logic txPush,
  // Configuration to the slave controller
  output logic [9:0] ownAddress,
  output logic wideAddressEnable,
  output logic clockStretchEnable,
  output logic refuseAddress,
  output logic refuseData,
  output logic readSourceSelect,
  output logic [7:0] expectedByteCount,
  // Events from the slave controller
  input wire logic [7:0] groupOneEvent,
  input wire logic [6:0] groupTwoEvent,
  // External master data routing
  input wire logic [7:0] extWrByte,
  input wire logic extWrValid,
  output logic [7:0] rxFifoWrByte,
  output logic rxFifoWrEn,
  input wire logic [7:0] txFifoByte,
  input wire logic [7:0] fileByte,
  output logic [7:0] slaveReadByte,
  // Master controller register window
  output logic mstRdReq,
  output logic [7:0] mstRdOfs,
  input wire logic [7:0] mstRdata,
  output logic mstWrReq,
  output logic [7:0] mstWrOfs,
  output logic [7:0] mstWdata
);

  logic rdReq;
  logic rdMaster;
  logic [11:0] rdOfs;
  logic wrReq;
  logic wrMaster;
  logic [11:0] wrOfs;
  logic [7:0] wByte;

  logic [6:0] ownLo_ff, nxt_ownLo;
  logic [2:0] ownHi_ff, nxt_ownHi;
  logic [7:0] ctl_ff, nxt_ctl;
  logic [7:0] byteCnt_ff, nxt_byteCnt;
  logic [7:0] flags1_ff, nxt_flags1;
  logic [7:0] mask1_ff, nxt_mask1;
  logic [7:0] flags2_ff, nxt_flags2;
  logic [7:0] mask2_ff, nxt_mask2;
  logic irq_ff, nxt_irq;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [7:0] txByte_ff, nxt_txByte;
  logic txPush_ff, nxt_txPush;
  logic [7:0] rxWrByte_ff, nxt_rxWrByte;
  logic rxWrEn_ff, nxt_rxWrEn;
  logic [7:0] slvRd_ff, nxt_slvRd;
  logic mstWrReq_ff, nxt_mstWrReq;
  logic [7:0] mstWrOfs_ff, nxt_mstWrOfs;
  logic [7:0] mstWdata_ff, nxt_mstWdata;

  // Write strobe for one slave register
  function automatic logic hitWr(input logic req, input logic mst,
                                 input logic [11:0] ofs, input logic [11:0] reg_ofs);
    hitWr = req && !mst && (ofs == reg_ofs);
  endfunction

  smb_ahb_if #(
    .ADDR_W(ADDR_W),
    .BASE_ADDR(BASE_ADDR),
    .MASTER_EN(MASTER_EN)
  ) u_ahb (
    .ref_clk(ref_clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rdReq(rdReq),
    .rdMaster(rdMaster),
    .rdOfs(rdOfs),
    .wrReq(wrReq),
    .wrMaster(wrMaster),
    .wrOfs(wrOfs)
  );

  assign wByte = hwdata[7:0];

  // Configuration and flag registers
  always_comb begin
    nxt_ownLo = ownLo_ff;
    nxt_ownHi = ownHi_ff;
    nxt_ctl = ctl_ff;
    nxt_byteCnt = byteCnt_ff;
    nxt_mask1 = mask1_ff;
    nxt_mask2 = mask2_ff;
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_ADDR_LO)) begin
      nxt_ownLo = wByte[6:0];
    end
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_ADDR_HI)) begin
      nxt_ownHi = wByte[2:0];
    end
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_CONTROL)) begin
      nxt_ctl = wByte & CTL_MASK;
    end
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_BYTE_CNT)) begin
      nxt_byteCnt = wByte;
    end
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_MASK1)) begin
      nxt_mask1 = wByte;
    end
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_MASK2)) begin
      nxt_mask2 = wByte & MASK2_MASK;
    end
    // An event in the clearing cycle survives: set is applied after clear
    nxt_flags1 = flags1_ff;
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_FLAGS1)) begin
      nxt_flags1 = flags1_ff & ~wByte;
    end
    nxt_flags1 = nxt_flags1 | groupOneEvent;
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_FORCE1)) begin
      nxt_flags1 = nxt_flags1 | wByte;
    end
    nxt_flags2 = flags2_ff;
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_FLAGS2)) begin
      nxt_flags2 = flags2_ff & ~wByte;
    end
    nxt_flags2 = (nxt_flags2 | {1'b0, groupTwoEvent}) & FLAGS2_MASK;
    if (hitWr(wrReq, wrMaster, wrOfs, OFS_FORCE2)) begin
      nxt_flags2 = nxt_flags2 | (wByte & MASK2_MASK);
    end
    // Check flags have no enable, so they never reach the output
    nxt_irq = |(nxt_flags1 & nxt_mask1) || |(nxt_flags2 & nxt_mask2);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ownLo_ff <= OWN_ADDR[6:0];
      ownHi_ff <= OWN_ADDR[9:7];
      ctl_ff <= RST_CONTROL | {7'h00, WIDE_ADDR};
      byteCnt_ff <= RST_BYTE_CNT;
      flags1_ff <= RST_IRQ;
      mask1_ff <= RST_IRQ;
      flags2_ff <= RST_IRQ;
      mask2_ff <= RST_IRQ;
      irq_ff <= 1'b0;
    end else begin
      ownLo_ff <= nxt_ownLo;
      ownHi_ff <= nxt_ownHi;
      ctl_ff <= nxt_ctl;
      byteCnt_ff <= nxt_byteCnt;
      flags1_ff <= nxt_flags1;
      mask1_ff <= nxt_mask1;
      flags2_ff <= nxt_flags2;
      mask2_ff <= nxt_mask2;
      irq_ff <= nxt_irq;
    end
  end

  // Read data, taken in the address phase from next values so that a write
  // in the preceding data phase is already visible
  always_comb begin
    nxt_hrdata = hrdata_ff;
    if (rdReq) begin
      nxt_hrdata = 32'h0000_0000;
      if (rdMaster) begin
        nxt_hrdata = {24'h00_0000, mstRdata};
      end else begin
        unique case (rdOfs)
          OFS_DATA: nxt_hrdata = {24'h00_0000, rxByte};
          OFS_ADDR_LO: nxt_hrdata = {25'h000_0000, nxt_ownLo};
          OFS_ADDR_HI: nxt_hrdata = {29'h0000_0000, nxt_ownHi};
          OFS_CONTROL: nxt_hrdata = {24'h00_0000, nxt_ctl};
          OFS_BYTE_CNT: nxt_hrdata = {24'h00_0000, nxt_byteCnt};
          OFS_FLAGS1: nxt_hrdata = {24'h00_0000, nxt_flags1};
          OFS_MASK1: nxt_hrdata = {24'h00_0000, nxt_mask1};
          OFS_FLAGS2: nxt_hrdata = {24'h00_0000, nxt_flags2};
          OFS_MASK2: nxt_hrdata = {24'h00_0000, nxt_mask2};
          // Force registers and reserved words read as zero
          default: nxt_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Data port strobes and routing of the external master's traffic
  always_comb begin
    nxt_txPush = hitWr(wrReq, wrMaster, wrOfs, OFS_DATA);
    nxt_txByte = nxt_txPush ? wByte : txByte_ff;
    nxt_rxWrEn = extWrValid;
    nxt_rxWrByte = extWrValid ? extWrByte : rxWrByte_ff;
    nxt_slvRd = ctl_ff[CTL_SRC] ? fileByte : txFifoByte;
    nxt_mstWrReq = wrReq && wrMaster;
    nxt_mstWrOfs = nxt_mstWrReq ? wrOfs[7:0] : mstWrOfs_ff;
    nxt_mstWdata = nxt_mstWrReq ? wByte : mstWdata_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata_ff <= 32'h0000_0000;
      txByte_ff <= 8'h00;
      txPush_ff <= 1'b0;
      rxWrByte_ff <= 8'h00;
      rxWrEn_ff <= 1'b0;
      slvRd_ff <= 8'h00;
      mstWrReq_ff <= 1'b0;
      mstWrOfs_ff <= 8'h00;
      mstWdata_ff <= 8'h00;
    end else begin
      hrdata_ff <= nxt_hrdata;
      txByte_ff <= nxt_txByte;
      txPush_ff <= nxt_txPush;
      rxWrByte_ff <= nxt_rxWrByte;
      rxWrEn_ff <= nxt_rxWrEn;
      slvRd_ff <= nxt_slvRd;
      mstWrReq_ff <= nxt_mstWrReq;
      mstWrOfs_ff <= nxt_mstWrOfs;
      mstWdata_ff <= nxt_mstWdata;
    end
  end

  // Pop in the address phase, so the byte lands in hrdata at the same edge
  assign rxPop = rdReq && !rdMaster && (rdOfs == OFS_DATA);
  assign mstRdReq = rdReq && rdMaster;
  assign mstRdOfs = rdOfs[7:0];

  assign hrdata = hrdata_ff;
  assign irqOut = irq_ff;
  assign txByte = txByte_ff;
  assign txPush = txPush_ff;
  assign rxFifoWrByte = rxWrByte_ff;
  assign rxFifoWrEn = rxWrEn_ff;
  assign slaveReadByte = slvRd_ff;
  assign mstWrReq = mstWrReq_ff;
  assign mstWrOfs = mstWrOfs_ff;
  assign mstWdata = mstWdata_ff;

  assign ownAddress = {ownHi_ff, ownLo_ff};
  assign wideAddressEnable = ctl_ff[CTL_WIDE];
  assign clockStretchEnable = ctl_ff[CTL_STRETCH];
  assign refuseAddress = ctl_ff[CTL_REF_ADDR];
  assign refuseData = ctl_ff[CTL_REF_DATA];
  assign readSourceSelect = ctl_ff[CTL_SRC];
  assign expectedByteCount = byteCnt_ff;

endmodule

// file: tb/smb_regs_sva.sv
/*
  Port checker for the mailbox register bank.
  Assumes hready is fed back from hreadyout and the base is passed by the bind.
*/
module smb_regs_sva
  import smb_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter logic [31:0] BASE_ADDR = DEF_BASE_ADDR
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Host bus
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Block side
  input wire logic irqOut,
  input wire logic rxPop,
  input wire logic [7:0] txByte,
  input wire logic txPush,
  input wire logic readSourceSelect,
  input wire logic [7:0] groupOneEvent,
  input wire logic [6:0] groupTwoEvent,
  input wire logic [7:0] extWrByte,
  input wire logic extWrValid,
  input wire logic [7:0] rxFifoWrByte,
  input wire logic rxFifoWrEn,
  input wire logic [7:0] txFifoByte,
  input wire logic [7:0] fileByte,
  input wire logic [7:0] slaveReadByte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  logic acc;
  logic cause;
  logic wrAcc_ff;
  logic nxt_wrAcc;
  assign acc = hsel && hready && htrans[1];
  // Only a host write or an event may move the interrupt
  assign cause = (|groupOneEvent) || (|groupTwoEvent) || wrAcc_ff;
  always_comb begin
    nxt_wrAcc = reset ? 1'b0 : acc && hwrite;
  end
  always_ff @(posedge ref_clk) begin
    wrAcc_ff <= nxt_wrAcc;
  end

  sequence s_err_resp;
    !hreadyout && hresp ##1 hreadyout && hresp;
  endsequence
  sequence s_port_write;
    acc && hwrite && haddr == BASE_ADDR[ADDR_W-1:0];
  endsequence
  sequence s_port_read;
    acc && !hwrite && haddr == BASE_ADDR[ADDR_W-1:0];
  endsequence

  a_err_two_cycle:
    assert property (acc && hsize > HSIZE_WORD |=> s_err_resp) else $error("bad error reply");
  a_irq_reset_low:
    assert property ($fell(reset) |-> !irqOut) else $error("irq high after reset");
  a_pop_on_read:
    assert property (s_port_read |-> rxPop) else $error("no pop on port read");
  a_pop_only_read:
    assert property (rxPop |-> s_port_read) else $error("stray pop");
  a_push_after_wr:
    assert property (s_port_write |-> ##2 txPush && txByte == $past(hwdata[7:0]))
      else $error("push missing or wrong");
  a_ext_routed:
    assert property (extWrValid |=> rxFifoWrEn && rxFifoWrByte == $past(extWrByte))
      else $error("external byte lost");
  a_read_source:
    assert property (1'b1 |=> slaveReadByte ==
      ($past(readSourceSelect) ? $past(fileByte) : $past(txFifoByte))) else $error("bad source");
  a_irq_rise_cause:
    assert property ($rose(irqOut) |-> $past(cause)) else $error("irq rose without cause");
  a_irq_fall_cause:
    assert property ($fell(irqOut) && !$past(reset) |-> $past(wrAcc_ff))
      else $error("irq fell without write");
endmodule

bind smb_regs smb_regs_sva #(.ADDR_W(ADDR_W), .BASE_ADDR(BASE_ADDR)) uChk (
  .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
  .hresp, .irqOut, .rxPop, .txByte, .txPush, .readSourceSelect, .groupOneEvent,
  .groupTwoEvent, .extWrByte, .extWrValid, .rxFifoWrByte, .rxFifoWrEn, .txFifoByte,
  .fileByte, .slaveReadByte
);

// file: tb/smb_queue_model.sv
/*
  Queue and data-source side of the bank.
  Assumes one received byte is consumed per pop strobe.
*/
module smb_queue_model (
  // Clock
  input wire logic ref_clk,
  // Queues
  input wire logic rxPop,
  output logic [7:0] rxByte,
  input wire logic txPush,
  input wire logic [7:0] txByte,
  output logic [7:0] lastTx,
  // Sources
  output logic [7:0] txFifoByte,
  output logic [7:0] fileByte,
  output logic [7:0] mstRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxByte = 8'h30;
    lastTx = 8'h00;
  end
  assign txFifoByte = 8'h7e;
  assign fileByte = 8'hf1;
  assign mstRdata = 8'h6d;
  always @(posedge ref_clk) begin
    if (rxPop) rxByte <= rxByte + 8'h01;
    if (txPush) lastTx <= txByte;
  end
endmodule

// file: tb/test_smb_regs.sv
/*
  Self-checking bench for the mailbox register bank.
  Assumes hready loops back from hreadyout and the queue model feeds data.
*/
module test_smb_regs
  import smb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Non-zero base and narrow address bus so the window decode is exercised
  localparam logic [31:0] TB_BASE = 32'h0000_3000;

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] groupOneEvent = 8'h00;
  logic [6:0] groupTwoEvent = 7'h00;
  logic [7:0] extWrByte = 8'h00;
  logic extWrValid = 1'b0;
  logic hready, hreadyout, hresp, irqOut, rxPop, txPush, rxFifoWrEn;
  logic wideAddressEnable, clockStretchEnable, refuseAddress, refuseData, readSourceSelect;
  logic [31:0] hrdata;
  logic [9:0] ownAddress;
  logic [7:0] rxByte, txByte, expectedByteCount, rxFifoWrByte, txFifoByte, fileByte;
  logic [7:0] slaveReadByte, mstRdata, lastTx;
  logic [7:0] mstRdOfs, mstWrOfs, mstWdata;
  logic mstRdReq, mstWrReq;
  logic [8:0] mstRdSeen = 9'h000;
  logic [23:0] cfg;
  // Per-offset values from 0x04 up to 0x2c, first byte first
  logic [87:0] rstVals = 88'h4505010000000000000000;
  logic [87:0] setVals = 88'h7f073bffffff0067670000;
  int nMismatch = 0;
  int samplesChecked = 0;
  int cycles = 0;

  assign hready = hreadyout;
  assign cfg = {ownAddress, wideAddressEnable, clockStretchEnable, refuseAddress, refuseData,
    readSourceSelect, expectedByteCount, irqOut};
  always #10 ref_clk = ~ref_clk;

  smb_regs #(.ADDR_W(16), .BASE_ADDR(TB_BASE), .OWN_ADDR(10'h2c5), .WIDE_ADDR(1'b1)) dut (
    .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .irqOut, .rxByte, .rxPop, .txByte, .txPush, .ownAddress,
    .wideAddressEnable, .clockStretchEnable, .refuseAddress, .refuseData, .readSourceSelect,
    .expectedByteCount, .groupOneEvent, .groupTwoEvent, .extWrByte, .extWrValid,
    .rxFifoWrByte, .rxFifoWrEn, .txFifoByte, .fileByte, .slaveReadByte, .mstRdReq,
    .mstRdOfs, .mstRdata, .mstWrReq, .mstWrOfs, .mstWdata
  );
  smb_queue_model part (
    .ref_clk, .rxPop, .rxByte, .txPush, .txByte, .lastTx, .txFifoByte, .fileByte, .mstRdata
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Next request goes out on the edge that ends this data phase
  task automatic req(input logic [31:0] a, input logic w, input logic [2:0] sz,
                     input logic [7:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= 16'(TB_BASE + a);
    hsize <= sz;
    @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    req(a, 1'b1, HSIZE_WORD, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    req(a, 1'b0, HSIZE_WORD, 8'h00);
    chk($sformatf("reg %h", a), {24'h0, e}, hrdata);
  endtask

  task automatic err(input logic [31:0] a, input logic [2:0] sz);
    req(a, 1'b0, sz, 8'h00);
    chk("error cycle one", 32'h1, {31'h0, hresp & ~hreadyout});
    @(posedge ref_clk);
    #1;
    chk("error cycle two", 32'h1, {31'h0, hresp & hreadyout});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic ev(input logic [7:0] g1, input logic [6:0] g2);
    @(posedge ref_clk);
    groupOneEvent <= g1;
    groupTwoEvent <= g2;
    @(posedge ref_clk);
    groupOneEvent <= 8'h00;
    groupTwoEvent <= 7'h00;
    #1;
  endtask

  // Master read strobe only stands in the address phase, so catch it here
  always @(posedge ref_clk) begin
    if (mstRdReq) begin
      mstRdSeen <= {1'b1, mstRdOfs};
    end
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      nMismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 11; i++) rdc(32'(4 * i + 4), rstVals[87 - 8 * i -: 8]);
    chk("config", {8'h0, 10'h2c5, 5'h10, 8'h00, 1'b0}, {8'h0, cfg});
    $display("test reset values done");
    for (int i = 0; i < 11; i++) wr(32'(4 * i + 4), 8'hff);
    for (int i = 0; i < 11; i++) rdc(32'(4 * i + 4), setVals[87 - 8 * i -: 8]);
    chk("config", {8'h0, 10'h3ff, 5'h1f, 8'hff, 1'b1}, {8'h0, cfg});
    $display("test write all done");
    wr(32'h14, 8'h00);
    rdc(32'h14, 8'hff);
    wr(32'h14, 8'h7f);
    rdc(32'h14, 8'h80);
    wr(32'h18, 8'h00);
    idle(1);
    chk("irq", 32'h1, {31'h0, irqOut});
    wr(32'h20, 8'hff);
    idle(1);
    chk("irq", 32'h0, {31'h0, irqOut});
    ev(8'h01, 7'h18);
    rdc(32'h20, 8'h18);
    rdc(32'h14, 8'h81);
    chk("irq", 32'h0, {31'h0, irqOut});
    wr(32'h18, 8'h01);
    idle(1);
    chk("irq", 32'h1, {31'h0, irqOut});
    // Event in the clearing data phase must survive the clear
    fork
      wr(32'h20, 8'hff);
      begin
        repeat (2) @(posedge ref_clk);
        groupTwoEvent <= 7'h01;
        @(posedge ref_clk);
        groupTwoEvent <= 7'h00;
      end
    join
    rdc(32'h20, 8'h01);
    $display("test interrupts done");
    rdc(32'h0, 8'h30);
    rdc(32'h0, 8'h31);
    wr(32'h0, 8'h5c);
    idle(2);
    chk("pushed byte", 32'h5c, {24'h0, lastTx});
    chk("slave read", 32'hf1, {24'h0, slaveReadByte});
    wr(32'h0c, 8'h00);
    idle(2);
    chk("slave read", 32'h7e, {24'h0, slaveReadByte});
    @(posedge ref_clk);
    extWrByte <= 8'h9c;
    extWrValid <= 1'b1;
    @(posedge ref_clk);
    extWrValid <= 1'b0;
    #1;
    chk("rx route", 32'h19c, {23'h0, rxFifoWrEn, rxFifoWrByte});
    $display("test data paths done");
    rdc(32'h404, 8'h6d);
    chk("master read", 32'h104, {23'h0, mstRdSeen});
    wr(32'h408, 8'hc3);
    idle(1);
    chk("master write", 32'h108c3, {15'h0, mstWrReq, mstWrOfs, mstWdata});
    err(32'h2000, HSIZE_WORD);
    err(32'hffff_fffc, HSIZE_WORD);
    err(32'h0c, 3'h3);
    rdc(32'h0c, 8'h00);
    $display("test windows done");
    stop_test();
  end
endmodule
